/* File: hdl/spm_ctrl.sv */
// Sleep and Idle power mode controller
//
// What this block does
// - Sleep stops system clock, on-chip oscillator and code execution
// - Idle halts CPU only; system clock and peripherals keep running
// - Clock-fail monitor is off for all of Sleep
// - In Sleep low-power RC clock runs while watchdog is enabled
// - Watchdog count is cleared in the same cycle Sleep takes effect
// - Sleep disables system-clocked peripherals
// - Sleep ends on enabled interrupt, any reset or watchdog time-out
// - Wake from Sleep restarts on clock source selected at entry
// - Entering Idle clears the watchdog count
// - In Idle RC clock runs if watchdog or clock-fail monitor enabled
// - Idle ends on enabled interrupt, any reset or watchdog time-out
// - Idle wake reapplies CPU clock at once
// - Interrupt during entry is deferred, then wakes the device except from retention Sleep
// - Retention regulator only when config fuse is 0 and enable bit 1
// - Retention regulator applied only in Sleep
// - Fast-wake bit keeps regulator band gaps on during Sleep
// - Retention and fast-wake bits pick one of four Sleep variants
// - During lockout only power-on reset or master clear exits
// - Interrupts in lockout are discarded; wake needs a fresh assertion
// - Lockout counts RC periods: 2 plus wake-up if stopped, else 1
// - After lockout every standard Sleep exit ends retention Sleep
// - New oscillator select is writable only while clocks are unlocked
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module spm_ctrl (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire spm_pkg::spm_req_s req,
  input  wire logic            irq_pending,
  input  wire logic            wdog_timeout,
  input  wire logic            soft_reset,
  input  wire logic            por_reset,
  input  wire logic            master_clear_pin,
  input  wire logic            retention_config_fuse,
  input  wire logic            rc_tick,
  input  wire logic            rc_running,
  input  wire logic [3:0]      reg_addr,
  input  wire logic [15:0]     reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [15:0]          reg_rdata,
  output logic                 req_ack,
  output logic                 wake,
  output spm_pkg::spm_ctl_s    ctl,
  output logic [2:0]           osc_select,
  output spm_pkg::spm_variant_e variant
);

  spm_pkg::spm_state_e    state_reg;
  spm_pkg::spm_state_e    state_next;
  logic [15:0]            ctrl_reg;
  logic [2:0]             new_osc_reg;
  logic [2:0]             entry_osc_reg;
  logic                   in_ret_reg;
  logic [3:0]             lock_cnt_reg;
  logic                   irq_prev_reg;
  logic                   fresh_reg;
  logic                   wake_cause;
  logic                   hard_exit;
  logic                   ret_sel;
  spm_pkg::spm_ctl_s      ctl_next;

  // Standard exit causes shared by Sleep and Idle
  function automatic logic std_exit(input logic irq,
                                    input logic wdog,
                                    input logic sreset,
                                    input logic hard);
    std_exit = irq || wdog || sreset || hard;
  endfunction

  assign ret_sel   = ctrl_reg[spm_pkg::CTRL_RET_EN_BIT] && !retention_config_fuse;
  assign hard_exit = por_reset || master_clear_pin;
  assign wake_cause = (in_ret_reg && lock_cnt_reg != 4'h0) ? hard_exit :
                      (in_ret_reg ? std_exit(fresh_reg, wdog_timeout, soft_reset, hard_exit) :
                      std_exit(irq_pending, wdog_timeout, soft_reset, hard_exit));

  // Register writes
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg    <= spm_pkg::CTRL_RESET;
      new_osc_reg <= spm_pkg::OSC_RESET;
    end else if (reg_wr) begin
      if (reg_addr == spm_pkg::CTRL_ADDR) begin
        ctrl_reg <= reg_wdata;
      end
      if (reg_addr == spm_pkg::OSC_ADDR && !ctrl_reg[spm_pkg::CTRL_LOCK_BIT]) begin
        new_osc_reg <= reg_wdata[2:0];
      end
    end
  end

  // Register reads, data one cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        spm_pkg::CTRL_ADDR:   reg_rdata <= ctrl_reg;
        spm_pkg::STATUS_ADDR: reg_rdata <= {9'h000, lock_cnt_reg, in_ret_reg,
                                            state_reg == spm_pkg::SPM_SLEEP,
                                            state_reg == spm_pkg::SPM_IDLE};
        spm_pkg::OSC_ADDR:    reg_rdata <= {13'h0000, new_osc_reg};
        default:              reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Mode sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      spm_pkg::SPM_RUN:   if (req.req) state_next = spm_pkg::SPM_ENTER;
      // Interrupts are held off during entry
      spm_pkg::SPM_ENTER: state_next = req.sel_idle ? spm_pkg::SPM_IDLE : spm_pkg::SPM_SLEEP;
      spm_pkg::SPM_SLEEP: if (wake_cause) state_next = spm_pkg::SPM_WAKE;
      spm_pkg::SPM_IDLE:  if (std_exit(irq_pending, wdog_timeout, soft_reset, hard_exit)) begin
        state_next = spm_pkg::SPM_WAKE;
      end
      spm_pkg::SPM_WAKE:  state_next = spm_pkg::SPM_RUN;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= spm_pkg::SPM_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Retention lockout timer on RC ticks
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_ret_reg   <= 1'b0;
      lock_cnt_reg <= 4'h0;
    end else if (state_reg == spm_pkg::SPM_ENTER && !req.sel_idle) begin
      in_ret_reg   <= ret_sel;
      lock_cnt_reg <= !ret_sel ? 4'h0 :
                      (rc_running ? spm_pkg::LOCK_PER_RUNNING :
                      4'(spm_pkg::LOCK_PER_STOPPED + spm_pkg::RC_WAKE_PER));
    end else if (state_reg != spm_pkg::SPM_SLEEP) begin
      in_ret_reg   <= 1'b0;
      lock_cnt_reg <= 4'h0;
    end else if (rc_tick && lock_cnt_reg != 4'h0) begin
      lock_cnt_reg <= lock_cnt_reg - 4'h1;
    end
  end

  // Fresh interrupt edge after lockout
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_prev_reg <= 1'b0;
      fresh_reg    <= 1'b0;
    end else begin
      irq_prev_reg <= irq_pending;
      if (!in_ret_reg || lock_cnt_reg != 4'h0) begin
        fresh_reg <= 1'b0;
      end else if (irq_pending && !irq_prev_reg) begin
        fresh_reg <= 1'b1;
      end
    end
  end

  // Clock source captured at Sleep entry
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      entry_osc_reg <= spm_pkg::OSC_RESET;
      osc_select    <= spm_pkg::OSC_RESET;
    end else begin
      if (state_reg == spm_pkg::SPM_ENTER) begin
        entry_osc_reg <= new_osc_reg;
      end
      if (state_reg == spm_pkg::SPM_WAKE) begin
        osc_select <= entry_osc_reg;
      end else if (state_reg == spm_pkg::SPM_RUN) begin
        osc_select <= new_osc_reg;
      end
    end
  end

  // Clock and power control outputs
  always_comb begin
    ctl_next = '{sys_clk_en: 1'b1, cpu_clk_en: 1'b1, osc_en: 1'b1,
                 rc_clk_en: ctrl_reg[spm_pkg::CTRL_WDOG_EN_BIT] || ctrl_reg[spm_pkg::CTRL_CFMEN_BIT],
                 cfm_en: ctrl_reg[spm_pkg::CTRL_CFMEN_BIT], periph_en: 1'b1,
                 ret_reg_en: 1'b0, bandgap_en: 1'b1, wdog_clear: 1'b0};
    unique case (state_next)
      spm_pkg::SPM_SLEEP: begin
        ctl_next.sys_clk_en = 1'b0;
        ctl_next.osc_en     = 1'b0;
        ctl_next.cpu_clk_en = 1'b0;
        ctl_next.cfm_en     = 1'b0;
        ctl_next.periph_en  = 1'b0;
        ctl_next.rc_clk_en  = ctrl_reg[spm_pkg::CTRL_WDOG_EN_BIT];
        ctl_next.ret_reg_en = ret_sel;
        ctl_next.bandgap_en = ctrl_reg[spm_pkg::CTRL_FAST_WAKE_BIT];
      end
      spm_pkg::SPM_IDLE: begin
        ctl_next.cpu_clk_en = 1'b0;
      end
      default: begin
        ctl_next.cpu_clk_en = 1'b1;
      end
    endcase
    if (state_reg == spm_pkg::SPM_ENTER) begin
      ctl_next.wdog_clear = ctrl_reg[spm_pkg::CTRL_WDOG_EN_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl     <= '{sys_clk_en: 1'b1, cpu_clk_en: 1'b1, osc_en: 1'b1, rc_clk_en: 1'b0,
                   cfm_en: 1'b0, periph_en: 1'b1, ret_reg_en: 1'b0, bandgap_en: 1'b1,
                   wdog_clear: 1'b0};
      req_ack <= 1'b0;
      wake    <= 1'b0;
      variant <= spm_pkg::SPM_SLEEP_PLAIN;
    end else begin
      ctl     <= ctl_next;
      req_ack <= state_reg == spm_pkg::SPM_ENTER;
      wake    <= state_reg == spm_pkg::SPM_WAKE;
      variant <= spm_pkg::spm_variant_e'({ret_sel, ctrl_reg[spm_pkg::CTRL_FAST_WAKE_BIT]});
    end
  end

endmodule
`default_nettype wire

/* File: hdl/spm_pkg.sv */
// Package of constants and types for the sleep/idle power mode controller
package spm_pkg;
  // Register offsets (plain register port, word addressed)
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h1;
  localparam logic [3:0] OSC_ADDR    = 4'h2;
  // Control register fields
  localparam int CTRL_RET_EN_BIT    = 12;
  localparam int CTRL_FAST_WAKE_BIT = 8;
  localparam int CTRL_WDOG_EN_BIT   = 0;
  localparam int CTRL_CFMEN_BIT  = 1;
  localparam int CTRL_LOCK_BIT   = 2;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Oscillator select width and reset value
  localparam int OSC_W = 3;
  localparam logic [2:0] OSC_RESET = 3'h0;
  // Lockout in low-power RC periods
  localparam logic [3:0] LOCK_PER_RUNNING = 4'h1;
  localparam logic [3:0] LOCK_PER_STOPPED = 4'h2;
  // RC wake-up time counted in RC periods beyond the two above
  localparam logic [3:0] RC_WAKE_PER = 4'h1;

  typedef enum logic [1:0] {
    SPM_SLEEP_PLAIN = 2'h0,
    SPM_SLEEP_FAST  = 2'h1,
    SPM_SLEEP_RET   = 2'h2,
    SPM_SLEEP_FRET  = 2'h3
  } spm_variant_e;

  typedef enum {
    SPM_RUN,
    SPM_ENTER,
    SPM_SLEEP,
    SPM_IDLE,
    SPM_WAKE
  } spm_state_e;

  // Power-save request from the CPU core
  typedef struct packed {
    logic req;
    logic sel_idle;
  } spm_req_s;

  // Clock and power controls driven out
  typedef struct packed {
    logic sys_clk_en;
    logic cpu_clk_en;
    logic osc_en;
    logic rc_clk_en;
    logic cfm_en;
    logic periph_en;
    logic ret_reg_en;
    logic bandgap_en;
    logic wdog_clear;
  } spm_ctl_s;
endpackage

/* File: sim/spm_core_model.sv */
// CPU core model issuing power-save requests
`timescale 1ns/10ps
`default_nettype none
module spm_core_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        sel_idle,
  input  wire logic        req_ack,
  output spm_pkg::spm_req_s req
);
  // Request and selector stay put until the controller acknowledges
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      req <= '0;
    else if (req_ack)
      req.req <= 1'b0;
    else if (go)
      req <= '{1'b1, sel_idle};
  end
endmodule
`default_nettype wire

/* File: sim/spm_ctrl_checker.sv */
// Assertions on the power mode controller ports
`timescale 1ns/10ps
`default_nettype none
module spm_ctrl_checker (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire spm_pkg::spm_req_s     req,
  input wire logic                  irq_pending,
  input wire logic                  retention_config_fuse,
  input wire logic                  req_ack,
  input wire logic                  wake,
  input wire spm_pkg::spm_ctl_s     ctl,
  input wire spm_pkg::spm_variant_e variant
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_ack_two_late: assert property ($rose(req.req) |-> ##2 req_ack)
    else $error("ack not two cycles after request");
  a_sleep_clk_off: assert property (req_ack && !req.sel_idle |->
    !(ctl.sys_clk_en || ctl.cpu_clk_en || ctl.osc_en || ctl.periph_en))
    else $error("clocks left on in sleep");
  a_idle_sys_on: assert property (req_ack && req.sel_idle |->
    ctl.sys_clk_en && ctl.periph_en && !ctl.cpu_clk_en)
    else $error("idle clock pattern wrong");
  a_monitor_off: assert property (!ctl.sys_clk_en |-> !ctl.cfm_en)
    else $error("clock monitor on in sleep");
  a_ret_fuse_ok: assert property (ctl.ret_reg_en |-> !retention_config_fuse && variant[1])
    else $error("retention regulator without permission");
  a_ret_in_sleep: assert property (ctl.ret_reg_en |-> !ctl.sys_clk_en)
    else $error("retention regulator outside sleep");
  a_idle_irq_wake: assert property (ctl.sys_clk_en && !ctl.cpu_clk_en && irq_pending
    |-> ##[1:2] ctl.cpu_clk_en)
    else $error("idle not left on interrupt");
  a_wake_after_clk: assert property (wake |->
    $past(ctl.cpu_clk_en) && !$past(ctl.cpu_clk_en, 2))
    else $error("wake pulse not after clock return");
endmodule
bind spm_ctrl spm_ctrl_checker i_spm_ctrl_checker (.mclk(mclk), .rst(rst), .req(req),
  .irq_pending(irq_pending), .retention_config_fuse(retention_config_fuse),
  .req_ack(req_ack), .wake(wake), .ctl(ctl), .variant(variant));
`default_nettype wire

/* File: sim/spm_ctrl_test.sv */
// Self-checking bench for the power mode controller
`timescale 1ns/10ps
`default_nettype none
module spm_ctrl_test;
  logic                  mclk, rst, go, sel, fuse, tick, run, wr, rd, req_ack, wake;
  logic [4:0]            ev;
  logic [3:0]            addr;
  logic [15:0]           wdata, rdata;
  logic [2:0]            osc;
  spm_pkg::spm_req_s     req;
  spm_pkg::spm_ctl_s     ctl;
  spm_pkg::spm_variant_e variant;
  int                    mismatches, n_tests;
  spm_core_model i_spm_core_model (.mclk(mclk), .rst(rst), .go(go), .sel_idle(sel),
    .req_ack(req_ack), .req(req));
  spm_ctrl i_spm_ctrl (.mclk(mclk), .rst(rst), .req(req), .irq_pending(ev[0]),
    .wdog_timeout(ev[1]), .soft_reset(ev[2]), .por_reset(ev[3]),
    .master_clear_pin(ev[4]), .retention_config_fuse(fuse), .rc_tick(tick),
    .rc_running(run), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .req_ack(req_ack), .wake(wake), .ctl(ctl), .osc_select(osc),
    .variant(variant));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  // Writes control bits, issues the request and stops in the ack cycle
  task automatic enter(input logic [15:0] c, input logic i);
    wr_reg(spm_pkg::CTRL_ADDR, c);
    @(posedge mclk);
    go <= 1'b1;
    sel <= i;
    @(posedge mclk);
    go <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      #1;
      if (req_ack === 1'b1)
        break;
      @(posedge mclk);
    end
    chk(req_ack, 1'b1);
  endtask
  // Holds wake causes for n+1 cycles and reports whether wake pulsed in the last n
  task automatic cause(input logic [4:0] e, input int n, input logic x);
    logic w;
    w = 1'b0;
    @(posedge mclk);
    ev <= e;
    repeat (n) begin
      @(posedge mclk);
      #1;
      w = w | wake;
    end
    @(posedge mclk);
    ev <= '0;
    chk(w, x);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk);
      tick <= 1'b1;
      @(posedge mclk);
      tick <= 1'b0;
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    conclude();
  end
  initial begin
    {go, sel, fuse, tick, run, wr, rd, ev, addr, wdata} = '0;
    mismatches = 0;
    n_tests = 0;
    rst = 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(spm_pkg::CTRL_ADDR, spm_pkg::CTRL_RESET);
    rd_reg(4'hf, 16'h0000);
    wr_reg(spm_pkg::OSC_ADDR, 16'h0005);
    wr_reg(spm_pkg::CTRL_ADDR, 16'h0004);
    wr_reg(spm_pkg::OSC_ADDR, 16'h0002);
    rd_reg(spm_pkg::OSC_ADDR, 16'h0005);
    $display("test registers done");
    enter(16'h0001, 1'b0);
    chk({ctl.sys_clk_en, ctl.cpu_clk_en, ctl.osc_en, ctl.periph_en}, 4'h0);
    chk({ctl.cfm_en, ctl.rc_clk_en, ctl.wdog_clear}, 3'h3);
    chk(variant, spm_pkg::SPM_SLEEP_PLAIN);
    cause(5'h01, 5, 1'b1);
    chk(osc, 3'h5);
    $display("test sleep done");
    enter(16'h0002, 1'b1);
    chk({ctl.sys_clk_en, ctl.cpu_clk_en, ctl.periph_en, ctl.rc_clk_en, ctl.ret_reg_en}, 5'h16);
    cause(5'h02, 5, 1'b1);
    chk(ctl.cpu_clk_en, 1'b1);
    @(posedge mclk);
    ev <= 5'h01;
    enter(16'h0001, 1'b1);
    chk({ctl.cpu_clk_en, ctl.wdog_clear}, 2'h1);
    cause(5'h01, 5, 1'b1);
    $display("test idle done");
    @(posedge mclk);
    run <= 1'b1;
    enter(16'h1000, 1'b0);
    chk({ctl.ret_reg_en, ctl.sys_clk_en}, 2'h2);
    chk(variant, spm_pkg::SPM_SLEEP_RET);
    rd_reg(spm_pkg::STATUS_ADDR, 16'h000e);
    cause(5'h01, 4, 1'b0);
    ticks(1);
    cause(5'h00, 4, 1'b0);
    cause(5'h01, 5, 1'b1);
    @(posedge mclk);
    run <= 1'b0;
    enter(16'h1100, 1'b0);
    chk({ctl.ret_reg_en, ctl.bandgap_en}, 2'h3);
    chk(variant, spm_pkg::SPM_SLEEP_FRET);
    ticks(2);
    cause(5'h01, 4, 1'b0);
    ticks(1);
    cause(5'h01, 5, 1'b1);
    enter(16'h1000, 1'b0);
    cause(5'h10, 5, 1'b1);
    @(posedge mclk);
    fuse <= 1'b1;
    enter(16'h1100, 1'b0);
    chk({ctl.ret_reg_en, variant}, 3'h1);
    cause(5'h04, 5, 1'b1);
    $display("test retention done");
    conclude();
  end
endmodule
`default_nettype wire
